// file: hw/cbr_regs.svh
// register offsets, field positions, reset values, write masks and identity values of the config bank
`ifndef CBR_REGS_SVH
`define CBR_REGS_SVH
`define CBR_OFS_FREQ_SLEW      8'h03
`define CBR_OFS_RSVD4          8'h04
`define CBR_OFS_REV_VENDOR     8'h05
`define CBR_OFS_DEV_TYPE_ID    8'h06
`define CBR_OFS_READ_COUNT     8'h07
`define CBR_OFS_RSVD8          8'h08
`define CBR_OFS_RSVD9          8'h09
`define CBR_OFS_PD_RESTORE     8'h0A
`define CBR_BIT_FREQ_EN        5
`define CBR_BIT_FREQ_HI        4
`define CBR_BIT_FREQ_LO        3
`define CBR_BIT_FB_EDGE        0
`define CBR_BIT_KEEP_CFG       6
`define CBR_RST_FREQ_SLEW      8'hC7
`define CBR_RST_READ_COUNT     8'h08
`define CBR_RST_PD_RESTORE     8'h00
`define CBR_RST_RSVD           8'h00
`define CBR_MASK_FREQ_SLEW     8'h39
`define CBR_MASK_READ_COUNT    8'h1F
`define CBR_MASK_PD_RESTORE    8'h40
// neutral identity values, chosen arbitrarily
`define CBR_ID_REVISION        4'hA
`define CBR_ID_MAKER           4'h5
`define CBR_ID_PART_CLASS      2'h2
`define CBR_ID_PART_NUMBER     6'h15
`endif

// file: hw/cbr_pkg.sv
// types shared by the config bank modules
package cbr_pkg;
  typedef enum logic [1:0] {
    CBR_FREQ_100M = 2'h0,
    CBR_FREQ_50M  = 2'h1,
    CBR_FREQ_125M = 2'h2,
    CBR_FREQ_RSVD = 2'h3
  } cbr_freq_e;
  typedef enum logic [2:0] {
    CBR_ST_IDLE  = 3'h1,
    CBR_ST_COUNT = 3'h2,
    CBR_ST_DATA  = 3'h4
  } cbr_wr_st_e;
  typedef logic [7:0] cbr_byte_t;
endpackage

// file: hw/cbr_sync.sv
// three-stage pin synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module cbr_sync (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic clk_en_i,
  input  wire logic rst_val_i,
  // pin in, clean level out
  input  wire logic pin_i,
  output logic      level_o
);
  logic [2:0] stg_ff;
  logic [2:0] nxt_stg;
  logic       lvl_ff;
  logic       nxt_lvl;
  always_comb begin
    nxt_stg = {stg_ff[1:0], pin_i};
    nxt_lvl = (stg_ff[1] == stg_ff[2]) ? stg_ff[2] : lvl_ff;
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stg_ff <= 3'h0;
      lvl_ff <= 1'b0;
    end else if (clk_en_i) begin
      stg_ff <= nxt_stg;
      lvl_ff <= nxt_lvl;
    end
  end
  assign level_o = lvl_ff;
endmodule
`default_nettype wire

// file: hw/cbr_freq_dec.sv
// decodes the effective output frequency from the software code and the pin strap
`timescale 1ns/1ps
`default_nettype none
module cbr_freq_dec
  import cbr_pkg::*;
(
  // controls
  input  wire logic      sw_en_i,
  input  wire logic [1:0] sw_code_i,
  input  wire logic [1:0] pin_code_i,
  // result
  output cbr_freq_e      freq_o,
  output logic           code_rsvd_o
);
  // software code steers only while the enable is set
  always_comb begin
    freq_o      = cbr_freq_e'(sw_en_i ? sw_code_i : pin_code_i);
    code_rsvd_o = (freq_o == CBR_FREQ_RSVD);
  end
endmodule
`default_nettype wire

// file: hw/cbr_bank.sv
// configuration and identification bank, bytes 3 through 10, byte-wide access
`timescale 1ns/1ps
`default_nettype none
`include "cbr_regs.svh"
// Notes on behaviour
// [RULE1] byte 3 bit 5 enables software frequency selection; resets to 0
// [RULE2] byte 3 bits 4:3 pick 100M, 50M, 125M; 11 reserved; needs enable
// [RULE3] byte 3 bit 0 picks feedback edge rate, 1 fast; resets to 1
// [RULE4] byte 5 read-only: revision in 7:4, maker code in 3:0
// [RULE5] byte 6 returns fixed part class in 7:6 and part number in 5:0
// [RULE6] byte 7 bits 4:0 set block read length; resets to 8
// [RULE7] byte 10 bit 6 keeps config through power-down when 1, else clears
// [RULE8] bytes 4, 8 and 9 are reserved with no control effect
// [RULE9] block read returns the byte count first, then data bytes
// [RULE10] block write sends index, count, then bytes N to N+X-1, each acknowledged
// [RULE11] reserved and read-only bits ignore writes and read their defaults
// [RULE12] writable fields load defaults at power-on reset
module cbr_bank
  import cbr_pkg::*;
(
  // clock, reset, enable
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       clk_en_i,
  // byte access from the serial engine
  input  wire logic       wr_stb_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic [7:0]      rdata_o,
  // block write framing from the serial engine
  input  wire logic       blk_start_i,
  input  wire logic       blk_byte_i,
  input  wire logic [7:0] blk_data_i,
  output logic            blk_ack_o,
  output logic            blk_busy_o,
  // power-down pin and strap
  input  wire logic       pd_n_pin_i,
  input  wire logic [1:0] freq_strap_i,
  // block controls
  output cbr_freq_e       freq_o,
  output logic            freq_rsvd_o,
  output logic            fb_fast_edge_o,
  output logic [4:0]      read_len_o
);
  // ==========================================================
  // power-down pin
  logic pd_n_lvl;
  logic pd_n_d_ff;
  logic nxt_pd_n_d;
  logic pd_enter;
  cbr_sync u_pd_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .clk_en_i  (clk_en_i),
    .rst_val_i (1'b1),
    .pin_i     (pd_n_pin_i),
    .level_o   (pd_n_lvl)
  );
  assign pd_enter = pd_n_d_ff & ~pd_n_lvl;

  // ==========================================================
  // block write sequencer
  cbr_wr_st_e st_ff;
  cbr_wr_st_e nxt_st;
  logic [7:0] idx_ff;
  logic [7:0] nxt_idx;
  logic [7:0] left_ff;
  logic [7:0] nxt_left;
  logic       ack_ff;
  logic       nxt_ack;
  logic       bw_stb;
  logic [7:0] bw_addr;
  always_comb begin
    nxt_st   = st_ff;
    nxt_idx  = idx_ff;
    nxt_left = left_ff;
    nxt_ack  = 1'b0;
    bw_stb   = 1'b0;
    bw_addr  = idx_ff;
    unique case (st_ff)
      CBR_ST_IDLE: begin
        if (blk_start_i) begin
          nxt_idx = blk_data_i;
          nxt_ack = 1'b1; // RULE10
          nxt_st  = CBR_ST_COUNT;
        end
      end
      CBR_ST_COUNT: begin
        if (blk_byte_i) begin
          nxt_left = blk_data_i;
          nxt_ack  = 1'b1; // RULE10
          nxt_st   = (blk_data_i == 8'h00) ? CBR_ST_IDLE : CBR_ST_DATA;
        end
      end
      CBR_ST_DATA: begin
        if (blk_byte_i) begin
          bw_stb   = 1'b1;
          nxt_ack  = 1'b1; // RULE10
          nxt_idx  = idx_ff + 8'h01;
          nxt_left = left_ff - 8'h01;
          if (left_ff == 8'h01) begin
            nxt_st = CBR_ST_IDLE;
          end
        end
      end
      default: nxt_st = CBR_ST_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff     <= CBR_ST_IDLE;
      idx_ff    <= 8'h00;
      left_ff   <= 8'h00;
      ack_ff    <= 1'b0;
      pd_n_d_ff <= 1'b0;
    end else if (clk_en_i) begin
      st_ff     <= nxt_st;
      idx_ff    <= nxt_idx;
      left_ff   <= nxt_left;
      ack_ff    <= nxt_ack;
      pd_n_d_ff <= nxt_pd_n_d;
    end
  end
  assign nxt_pd_n_d = pd_n_lvl;
  assign blk_ack_o  = ack_ff;
  assign blk_busy_o = (st_ff != CBR_ST_IDLE);

  // ==========================================================
  // register storage
  logic       any_stb;
  logic [7:0] any_addr;
  logic [7:0] any_data;
  logic [7:0] freq_slew_ff;
  logic [7:0] nxt_freq_slew;
  logic [7:0] read_cnt_ff;
  logic [7:0] nxt_read_cnt;
  logic [7:0] pd_rest_ff;
  logic [7:0] nxt_pd_rest;
  logic       clear_cfg;

  // merge a writable field with fixed reserved bits
  function automatic logic [7:0] merge_field(input logic [7:0] old_v, input logic [7:0] new_v,
                                             input logic [7:0] mask);
    merge_field = (new_v & mask) | (old_v & ~mask);
  endfunction

  always_comb begin
    any_stb   = wr_stb_i | bw_stb;
    any_addr  = bw_stb ? bw_addr : addr_i;
    any_data  = bw_stb ? blk_data_i : wdata_i;
    clear_cfg = pd_enter & ~pd_rest_ff[`CBR_BIT_KEEP_CFG]; // RULE7
    nxt_freq_slew = freq_slew_ff;
    nxt_read_cnt  = read_cnt_ff;
    nxt_pd_rest   = pd_rest_ff;
    if (clear_cfg) begin
      nxt_freq_slew = `CBR_RST_FREQ_SLEW; // RULE7
      nxt_read_cnt  = `CBR_RST_READ_COUNT;
    end else if (any_stb) begin
      // bytes 4, 5, 6, 8, 9 have no storage, so writes there are dropped
      unique case (any_addr)
        `CBR_OFS_FREQ_SLEW:  nxt_freq_slew = merge_field(freq_slew_ff, any_data, `CBR_MASK_FREQ_SLEW); // RULE11
        `CBR_OFS_READ_COUNT: nxt_read_cnt  = merge_field(read_cnt_ff, any_data, `CBR_MASK_READ_COUNT); // RULE6
        `CBR_OFS_PD_RESTORE: nxt_pd_rest   = merge_field(pd_rest_ff, any_data, `CBR_MASK_PD_RESTORE); // RULE7
        default: ; // RULE8
      endcase
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      freq_slew_ff <= `CBR_RST_FREQ_SLEW; // RULE12
      read_cnt_ff  <= `CBR_RST_READ_COUNT; // RULE12
      pd_rest_ff   <= `CBR_RST_PD_RESTORE; // RULE12
    end else if (clk_en_i) begin
      freq_slew_ff <= nxt_freq_slew;
      read_cnt_ff  <= nxt_read_cnt;
      pd_rest_ff   <= nxt_pd_rest;
    end
  end

  // ==========================================================
  // read mux, registered
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  always_comb begin
    unique case (addr_i)
      `CBR_OFS_FREQ_SLEW:   nxt_rdata = freq_slew_ff;
      `CBR_OFS_REV_VENDOR:  nxt_rdata = {`CBR_ID_REVISION, `CBR_ID_MAKER}; // RULE4
      `CBR_OFS_DEV_TYPE_ID: nxt_rdata = {`CBR_ID_PART_CLASS, `CBR_ID_PART_NUMBER}; // RULE5
      `CBR_OFS_READ_COUNT:  nxt_rdata = read_cnt_ff;
      `CBR_OFS_PD_RESTORE:  nxt_rdata = pd_rest_ff;
      default:              nxt_rdata = `CBR_RST_RSVD; // RULE8
    endcase
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 8'h00;
    end else if (clk_en_i) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign rdata_o = rdata_ff;

  // ==========================================================
  // block controls
  cbr_freq_dec u_freq (
    .sw_en_i     (freq_slew_ff[`CBR_BIT_FREQ_EN]), // RULE1
    .sw_code_i   (freq_slew_ff[`CBR_BIT_FREQ_HI:`CBR_BIT_FREQ_LO]), // RULE2
    .pin_code_i  (freq_strap_i),
    .freq_o      (freq_o),
    .code_rsvd_o (freq_rsvd_o)
  );
  assign fb_fast_edge_o = freq_slew_ff[`CBR_BIT_FB_EDGE]; // RULE3
  // host reads this to frame block reads: count byte first, then this many data bytes
  assign read_len_o     = read_cnt_ff[4:0]; // RULE6 RULE9

  // ==========================================================
  // checks
  en_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !freq_slew_ff[`CBR_BIT_FREQ_EN] |-> freq_o == cbr_freq_e'(freq_strap_i))
    else $error("frequency followed software code while disabled"); // RULE1
  sw_code_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    freq_slew_ff[`CBR_BIT_FREQ_EN] |-> freq_o == cbr_freq_e'(freq_slew_ff[4:3]))
    else $error("enabled frequency code not applied"); // RULE2
  edge_rate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && wr_stb_i && !bw_stb && !clear_cfg && addr_i == `CBR_OFS_FREQ_SLEW
    |=> fb_fast_edge_o == $past(wdata_i[0]))
    else $error("feedback edge rate not written"); // RULE3
  id_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && addr_i == `CBR_OFS_REV_VENDOR |=> rdata_o == 8'hA5)
    else $error("identity byte wrong"); // RULE4
  part_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && addr_i == `CBR_OFS_DEV_TYPE_ID |=> rdata_o == 8'h95)
    else $error("part byte wrong"); // RULE5
  count_wr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && wr_stb_i && !bw_stb && !clear_cfg && addr_i == `CBR_OFS_READ_COUNT
    |=> read_len_o == $past(wdata_i[4:0]) && read_cnt_ff[7:5] == 3'h0)
    else $error("read count not stored"); // RULE6
  pd_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && clear_cfg |=> read_len_o == 5'h08 && freq_slew_ff == 8'hC7)
    else $error("config not cleared on power-down"); // RULE7
  rsvd_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && (addr_i == `CBR_OFS_RSVD4 || addr_i == `CBR_OFS_RSVD9) |=> rdata_o == 8'h00)
    else $error("reserved byte not zero"); // RULE8
  blk_ack_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && blk_byte_i && st_ff != CBR_ST_IDLE |=> blk_ack_o)
    else $error("block byte not acknowledged"); // RULE10
  rsvd_bits_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (freq_slew_ff & ~8'h39) == 8'hC6 && (pd_rest_ff & ~8'h40) == 8'h00)
    else $error("reserved bits changed"); // RULE11

  // ==========================================================
  // checks on held state and block framing
  rsvd_code_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    freq_slew_ff[`CBR_BIT_FREQ_EN] && freq_slew_ff[4:3] == 2'h3 |-> freq_rsvd_o)
    else $error("reserved frequency code not flagged"); // RULE2

  strap_code_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !freq_slew_ff[`CBR_BIT_FREQ_EN] && freq_strap_i != 2'h3 |-> !freq_rsvd_o)
    else $error("reserved flag raised while software code disabled"); // RULE1

  ro_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && any_stb && !clear_cfg && (any_addr == `CBR_OFS_REV_VENDOR || any_addr == `CBR_OFS_DEV_TYPE_ID)
    |=> $stable(freq_slew_ff) && $stable(read_cnt_ff) && $stable(pd_rest_ff))
    else $error("write to read-only byte changed state"); // RULE11

  rsvd_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && any_stb && !clear_cfg
    && (any_addr == `CBR_OFS_RSVD4 || any_addr == `CBR_OFS_RSVD8 || any_addr == `CBR_OFS_RSVD9)
    |=> $stable(freq_slew_ff) && $stable(read_cnt_ff) && $stable(pd_rest_ff))
    else $error("write to reserved byte changed state"); // RULE8

  keep_cfg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && pd_enter && pd_rest_ff[`CBR_BIT_KEEP_CFG] && !any_stb
    |=> $stable(freq_slew_ff) && $stable(read_cnt_ff))
    else $error("config lost in power-down while keep set"); // RULE7

  pd_self_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && clear_cfg |=> $stable(pd_rest_ff))
    else $error("restore byte changed by power-down clear"); // RULE7

  pd_edge_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && clear_cfg |=> fb_fast_edge_o)
    else $error("edge rate not back to fast after clear"); // RULE7

  blk_count_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && st_ff == CBR_ST_DATA && blk_byte_i && !clear_cfg && idx_ff == `CBR_OFS_READ_COUNT
    |=> read_len_o == $past(blk_data_i[4:0]))
    else $error("block data byte not stored at its index"); // RULE10

  blk_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && st_ff == CBR_ST_IDLE && !blk_start_i |=> !blk_ack_o)
    else $error("acknowledge without a block start"); // RULE10

  blk_done_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && st_ff == CBR_ST_DATA && blk_byte_i && left_ff == 8'h01 |=> !blk_busy_o)
    else $error("block write not ended after last byte"); // RULE10

  blk_step_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && st_ff == CBR_ST_DATA && blk_byte_i |=> idx_ff == $past(idx_ff) + 8'h01)
    else $error("block index not advanced"); // RULE10

  cfg_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && !any_stb && !clear_cfg
    |=> $stable(freq_slew_ff) && $stable(read_cnt_ff) && $stable(pd_rest_ff))
    else $error("config changed with no write"); // RULE11

  rd_follow_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && addr_i == `CBR_OFS_READ_COUNT |=> rdata_o == $past(read_cnt_ff))
    else $error("read count byte not returned"); // RULE6

  count_rsvd_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    read_cnt_ff[7:5] == 3'h0)
    else $error("read count reserved bits set"); // RULE11
endmodule
`default_nettype wire

// file: tb/cbr_host_model.sv
// host side byte engine model driving the config bank
`timescale 1ns/1ps
`default_nettype none
module cbr_host_model (
  // clock
  input  wire logic       ref_clk_i,
  // byte access
  output logic            wr_stb_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o,
  input  wire logic [7:0] rdata_i,
  // block write framing
  output logic            blk_start_o,
  output logic            blk_byte_o,
  output logic [7:0]      blk_data_o,
  input  wire logic       blk_ack_i
);
  initial begin
    {wr_stb_o, blk_start_o, blk_byte_o} = 3'h0;
    {addr_o, wdata_o, blk_data_o} = 24'h0;
  end
  // ==========
  // byte tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_stb_o <= 1'b1;
    addr_o   <= a;
    wdata_o  <= d;
    @(posedge ref_clk_i);
    wr_stb_o <= 1'b0;
    // released data never holds the old value
    wdata_o  <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    @(posedge ref_clk_i);
    #1;
    d = rdata_i;
  endtask
  // one framing byte, acknowledge sampled in the following cycle
  task automatic blk(input logic first, input logic [7:0] d, output logic ack);
    @(posedge ref_clk_i);
    blk_start_o <= first;
    blk_byte_o  <= ~first;
    blk_data_o  <= d;
    @(posedge ref_clk_i);
    {blk_start_o, blk_byte_o} <= 2'h0;
    blk_data_o <= ~d;
    #1;
    ack = blk_ack_i;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_cbr_bank.sv
// self-checking bench for the config bank
`timescale 1ns/1ps
`default_nettype none
`include "cbr_regs.svh"
module tb_cbr_bank
  import cbr_pkg::*;
;
  logic       ref_clk_i    = 1'b0;
  logic       rst_n_i      = 1'b0;
  logic       pd_n_pin_i   = 1'b1;
  logic [1:0] freq_strap_i = 2'h2;
  logic       wr_stb, blk_start, blk_byte, blk_ack, blk_busy, fb_fast, frsv, a;
  logic [7:0] addr, wdata, rdata, blk_data, v;
  logic [4:0] read_len;
  cbr_freq_e  freq;
  int         error_cnt = 0;
  int         n_tests   = 0;
  localparam logic [7:0] ID5 = {`CBR_ID_REVISION, `CBR_ID_MAKER};
  localparam logic [7:0] ID6 = {`CBR_ID_PART_CLASS, `CBR_ID_PART_NUMBER};
  always #5 ref_clk_i = ~ref_clk_i;
  cbr_bank i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .wr_stb_i(wr_stb),
    .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .blk_start_i(blk_start), .blk_byte_i(blk_byte),
    .blk_data_i(blk_data), .blk_ack_o(blk_ack), .blk_busy_o(blk_busy), .pd_n_pin_i(pd_n_pin_i),
    .freq_strap_i(freq_strap_i), .freq_o(freq), .freq_rsvd_o(frsv), .fb_fast_edge_o(fb_fast),
    .read_len_o(read_len));
  cbr_host_model i_host (.ref_clk_i(ref_clk_i), .wr_stb_o(wr_stb), .addr_o(addr), .wdata_o(wdata),
    .rdata_i(rdata), .blk_start_o(blk_start), .blk_byte_o(blk_byte), .blk_data_o(blk_data),
    .blk_ack_i(blk_ack));
  // ==========
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] o, input logic [7:0] exp);
    i_host.rd(o, v);
    chk(v, exp);
  endtask
  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
  endtask
  // pin low long enough for the three-flop synchroniser to see it
  task automatic pd_pulse();
    @(posedge ref_clk_i);
    pd_n_pin_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    pd_n_pin_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    chk(8'(fb_fast), 8'h01);
    chk(8'(read_len), 8'h08);
    chk(8'(freq), 8'(freq_strap_i));
    rchk(8'h03, 8'hC7);
    rchk(8'h05, ID5);
    rchk(8'h06, ID6);
    rchk(8'h07, 8'h08);
    rchk(8'h0A, 8'h00);
  endtask
  task automatic t_freq();
    for (int c = 0; c < 4; c++) begin
      i_host.wr(8'h03, 8'h20 | 8'(c << 3));
      #1;
      chk(8'(freq), 8'(c));
      chk(8'(frsv), 8'(c == 3));
      chk(8'(fb_fast), 8'h00);
      rchk(8'h03, 8'hE6 | 8'(c << 3));
    end
    i_host.wr(8'h03, 8'h09);
    #1;
    chk(8'(freq), 8'(freq_strap_i));
    chk(8'(fb_fast), 8'h01);
  endtask
  task automatic t_ro();
    for (int o = 4; o < 11; o++) begin
      i_host.wr(8'(o), 8'hFF);
    end
    rchk(8'h03, 8'hCF);
    for (int o = 4; o < 11; o++) begin
      rchk(8'(o), o == 7 ? 8'h1F : o == 10 ? 8'h40 : o == 5 ? ID5 : o == 6 ? ID6 : 8'h00);
    end
    chk(8'(read_len), 8'h1F);
  endtask
  task automatic t_blk();
    logic [7:0] seq [4];
    seq = '{8'h07, 8'h02, 8'h0C, 8'h15};
    i_host.blk(1'b0, 8'h1E, a);
    chk(8'(a), 8'h00);
    for (int k = 0; k < 4; k++) begin
      i_host.blk(k == 0, seq[k], a);
      chk(8'(a), 8'h01);
    end
    chk(8'(blk_busy), 8'h00);
    chk(8'(read_len), 8'h0C);
    rchk(8'h07, 8'h0C);
    rchk(8'h08, 8'h00);
  endtask
  task automatic t_pd();
    i_host.wr(8'h03, 8'h21);
    pd_pulse();
    rchk(8'h03, 8'hE7);
    rchk(8'h07, 8'h0C);
    i_host.wr(8'h0A, 8'h00);
    pd_pulse();
    rchk(8'h03, 8'hC7);
    chk(8'(read_len), 8'h08);
    rchk(8'h0A, 8'h00);
  endtask
  initial begin
    do_reset();
    t_reset();
    t_freq();
    t_ro();
    t_blk();
    t_pd();
    i_host.wr(8'h07, 8'h03);
    do_reset();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
